// [dv/cpu_instruction_cycle_timing_test.sv]
// Self-checking bench for the instruction cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module cpu_instruction_cycle_timing_test;
  logic mclk = 0, resetn = 0, issue_valid = 0, branch_fail = 0;
  logic [7:0] issue_opcode = 8'h00;
  wire ready, done, bfetch, cond, taken, ext_rd, ext_wr, ext_wide, cfetch, strobe, acc_load, mul, div, nop;
  wire [1:0] len;
  wire [3:0] clocks, phase;
  int err_count = 0, checks = 0, cyc = 0, exp_rd = 0, exp_wr = 0, reads, writes;
  logic [31:0] seed = 32'h136e, got, want;
  logic [31:0] exp_q[$];
  // Opcode, bytes, taken clocks, conditional flag
  logic [19:0] tbl [0:47] = '{20'h28110, 20'h25220, 20'h26120, 20'h24220, 20'h38110, 20'h95220, 20'h96120,
    20'h94220, 20'h53330, 20'h62220, 20'h46120, 20'h64220, 20'he4110, 20'hf4110, 20'h23110, 20'h33110,
    20'hc4110, 20'h85330, 20'h75330, 20'he8110, 20'hf6120, 20'h76220, 20'ha6220, 20'h90330, 20'h93130,
    20'h83130, 20'he0130, 20'he2130, 20'he3130, 20'hf0130, 20'hf2130, 20'hf3130, 20'ha4140, 20'h84180,
    20'ha5110, 20'h00110, 20'hb6351, 20'h40231, 20'h20341, 20'h04110, 20'h06120, 20'h05220, 20'ha3110,
    20'h14110, 20'h16120, 20'h22150, 20'hb4341, 20'h12340};
  cpu_instruction_cycle_timing u_dut (.mclk(mclk), .resetn(resetn), .issue_valid(issue_valid),
    .issue_opcode(issue_opcode), .branch_fail(branch_fail), .ready_q(ready), .done_q(done), .len_q(len),
    .clocks_q(clocks), .phase_q(phase), .byte_fetch_q(bfetch), .cond_q(cond), .taken_q(taken),
    .ext_data_move_rd_q(ext_rd), .ext_data_move_wr_q(ext_wr), .ext_data_move_wide_q(ext_wide),
    .code_byte_fetch_q(cfetch), .flash_strobe_q(strobe), .acc_load_q(acc_load),
    .multiply_acc_second_q(mul), .divide_acc_second_q(div), .nop_q(nop));
  flash_data_model u_mem (.mclk(mclk), .resetn(resetn), .strobe(strobe), .rd(ext_rd), .wr(ext_wr),
    .fetch(cfetch), .reads(reads), .writes(writes));
  // Clock and cycle count
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected {bytes, clocks, class flags}; a failed branch drops one clock
  function automatic logic [15:0] expv(input logic [7:0] op, input logic fail);
    logic [19:0] t;
    logic rd, wr, cf;
    t = 20'h0;
    foreach (tbl[i])
      if (tbl[i][19:12] == op)
        t = tbl[i];
    rd = op inside {8'he0, 8'he2, 8'he3};
    wr = op inside {8'hf0, 8'hf2, 8'hf3};
    cf = op inside {8'h83, 8'h93};
    return {t[9:8], t[7:4] - {3'h0, t[0] & fail}, t[0], t[0] & ~fail, rd, wr, op == 8'he0 || op == 8'hf0,
      cf, op == 8'ha4, op == 8'h84, op == 8'h00 || op == 8'ha5, rd | cf};
  endfunction
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Valid stays up between issues so back-to-back ones need no gap
  task automatic issue(input logic [7:0] op, input logic fail);
    logic [15:0] e;
    e = expv(op, fail);
    issue_valid <= 1'b1;
    issue_opcode <= op;
    branch_fail <= fail;
    @(posedge mclk);
    while (ready !== 1'b1) @(posedge mclk);
    exp_q.push_back({e, cyc[15:0] + {12'h0, e[13:10]}});
    exp_rd += e[0];
    exp_wr += e[6];
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Each finished instruction takes the oldest note
  always @(posedge mclk)
    if (resetn === 1'b1 && done === 1'b1)
    begin
      got = {len, clocks, cond, taken, ext_rd, ext_wr, ext_wide, cfetch, mul, div, nop, acc_load, cyc[15:0]};
      want = exp_q.size() ? exp_q.pop_front() : 32'hx;
      compare(got, want);
    end
  // Watchdog well past the expected run length
  initial
  begin
    #(20000 * 5);
    err_count++;
    tally_and_finish();
  end
  // Every table entry both ways, then random traffic
  initial
  begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    foreach (tbl[i])
    begin
      issue(tbl[i][19:12], 1'b0);
      issue(tbl[i][19:12], 1'b1);
    end
    repeat (300)
    begin
      seed = lfsr(seed);
      issue(tbl[seed[15:0] % 48][19:12], seed[20]);
    end
    issue_valid <= 1'b0;
    repeat (12) @(posedge mclk);
    compare(exp_q.size(), 0);
    compare(reads, exp_rd);
    compare(writes, exp_wr);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [dv/cycle_timing_chk.sv]
// Timing assertions for the instruction cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module cycle_timing_chk (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic issue_valid,
  input wire logic [7:0] issue_opcode,
  input wire logic branch_fail,
  input wire logic ready_q,
  input wire logic done_q,
  input wire logic [1:0] len_q,
  input wire logic [3:0] clocks_q,
  input wire logic [3:0] phase_q,
  input wire logic byte_fetch_q,
  input wire logic taken_q,
  input wire logic code_byte_fetch_q,
  input wire logic flash_strobe_q,
  input wire logic acc_load_q,
  input wire logic nop_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_take(logic [7:0] op);
    ready_q && issue_valid && issue_opcode == op;
  endsequence
  sequence s_fetch;
    ##1 code_byte_fetch_q && byte_fetch_q ##1 flash_strobe_q && !byte_fetch_q ##1 done_q && acc_load_q;
  endsequence
  property p_div; s_take(8'h84) |-> ##1 !done_q [*7] ##1 done_q; endproperty
  property p_mul; s_take(8'ha4) |-> ##1 !done_q [*3] ##1 done_q; endproperty
  property p_nop; s_take(8'ha5) |-> ##1 done_q && nop_q && clocks_q == 4'h1; endproperty
  property p_code; s_take(8'h93) |-> s_fetch; endproperty
  property p_ext;
    ready_q && issue_valid && issue_opcode inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3}
      |-> ##1 !done_q ##1 flash_strobe_q ##1 done_q;
  endproperty
  property p_skip; s_take(8'h40) ##0 branch_fail |-> ##1 !done_q ##1 done_q && !taken_q; endproperty
  property p_jump; s_take(8'h40) ##0 !branch_fail |-> ##1 !done_q [*2] ##1 done_q && taken_q; endproperty
  property p_compare_jump_unequal; s_take(8'hb6) ##0 branch_fail |-> ##1 !done_q [*3] ##1 done_q; endproperty
  property p_data_pointer16; s_take(8'h90) |-> ##1 (len_q == 2'h3 && byte_fetch_q) [*3] ##0 done_q; endproperty
  property p_bytes; !(ready_q && !done_q) |-> byte_fetch_q == (phase_q < {2'h0, len_q}); endproperty
  property p_phase; done_q |-> ready_q && phase_q == clocks_q - 4'h1; endproperty
  a_div: assert property (p_div) else $error("divide length wrong");
  a_mul: assert property (p_mul) else $error("multiply length wrong");
  a_nop: assert property (p_nop) else $error("unused opcode not a no-op");
  a_code: assert property (p_code) else $error("code fetch sequence wrong");
  a_ext: assert property (p_ext) else $error("data move sequence wrong");
  a_skip: assert property (p_skip) else $error("branch not taken length wrong");
  a_jump: assert property (p_jump) else $error("branch taken length wrong");
  a_compare_jump_unequal: assert property (p_compare_jump_unequal) else $error("compare jump length wrong");
  a_data_pointer16: assert property (p_data_pointer16) else $error("pointer load length wrong");
  a_bytes: assert property (p_bytes) else $error("byte fetch marking wrong");
  a_phase: assert property (p_phase) else $error("final phase wrong");
endmodule
bind cpu_instruction_cycle_timing cycle_timing_chk u_chk (.mclk, .resetn, .issue_valid, .issue_opcode,
  .branch_fail, .ready_q, .done_q, .len_q, .clocks_q, .phase_q, .byte_fetch_q, .taken_q, .code_byte_fetch_q,
  .flash_strobe_q, .acc_load_q, .nop_q);
`default_nettype wire

// [dv/flash_data_model.sv]
// Program flash and data memory stand-in that counts sequencer accesses
`timescale 1ns/10ps
`default_nettype none
module flash_data_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic strobe,
  input wire logic rd,
  input wire logic wr,
  input wire logic fetch,
  output var int reads,
  output var int writes
);
  // One flash access per strobe; a strobe with no mode flag counts nothing
  always @(posedge mclk or negedge resetn)
    if (!resetn)
    begin
      reads <= 0;
      writes <= 0;
    end
    else if (strobe)
    begin
      reads <= reads + int'(rd | fetch);
      writes <= writes + int'(wr);
    end
endmodule
`default_nettype wire

// [hdl/cpu_instruction_cycle_timing.v]
// Instruction length and clock-count sequencer for the pipelined 8-bit core
`timescale 1ns/10ps
`default_nettype none
`include "cpu_timing_defines.vh"
// Function
// - Every one of the 256 opcodes decodes with its classic encoding and meaning
// - Execution is counted in single system clocks, never in machine cycles
// - No instruction exceeds eight clocks; divide takes 8, multiply takes 4
// - A conditional branch not taken finishes one clock earlier than taken
// - Most instructions take as many clocks as they have bytes
// - External-data moves go to the on-chip program flash, no external bus
// - The table covers all instructions in the clock classes 1 to 8
// - Add and add-with-carry: direct 2/2, indirect 1/2, immediate 2/2, register 1/1
// - Subtract-with-borrow: register 1/1, direct 2/2, indirect 1/2, immediate 2/2
// - Logic ops: register 1/1, direct or immediate 2/2, indirect 1/2, to-direct 2/2 or 3/3
// - Accumulator-only clear, complement, rotates and nibble swap take one byte, one clock
// - Register moves 1/1, direct or immediate 2/2, into direct 3/3
// - Accumulator to indirect 1 byte 2 clocks; direct or immediate to indirect 2/2
// - Loading the data pointer with a constant takes 3 bytes, 3 clocks
// - Code byte fetch is one byte, 3 clocks, and loads the accumulator
// - Back-to-back single-clock instructions give one instruction per clock
// - The single unused opcode behaves exactly like no-operation
// - Compare-jump on indirect location: 3 bytes, 4 clocks not taken, 5 taken
// - Each external-data move form is one byte and three clocks

module cpu_instruction_cycle_timing (
  input wire mclk,
  input wire resetn,
  input wire issue_valid,
  input wire [7:0] issue_opcode,
  input wire branch_fail,
  output reg ready_q,
  output reg done_q,
  output reg [1:0] len_q,
  output reg [3:0] clocks_q,
  output reg [3:0] phase_q,
  output reg byte_fetch_q,
  output reg cond_q,
  output reg taken_q,
  output reg ext_data_move_rd_q,
  output reg ext_data_move_wr_q,
  output reg ext_data_move_wide_q,
  output reg code_byte_fetch_q,
  output reg flash_strobe_q,
  output reg acc_load_q,
  output reg multiply_acc_second_q,
  output reg divide_acc_second_q,
  output reg nop_q
);

  // Timing entry for one opcode, taken-path count for branches
  function [`ENT_W-1:0] decode;
    input [7:0] op;
    begin
      decode = `ENT_1_1;
      if (op[3])
      begin
        // Bank register column
        case (op[7:4])
          4'h7, 4'h8, 4'ha: decode = `ENT_2_2;
          4'hb: decode = `ENT_B_3_4;
          4'hd: decode = `ENT_B_2_3;
          default: decode = `ENT_1_1;
        endcase
      end
      else if (op[2:1] == 2'b11)
      begin
        // Indirect pointer column
        case (op[7:4])
          4'h7, 4'h8, 4'ha: decode = `ENT_2_2;
          4'hb: decode = `ENT_B_3_5;
          default: decode = `ENT_1_2;
        endcase
      end
      else
      begin
        case (op[3:0])
          4'h1: decode = `ENT_2_3;
          4'h5:
          begin
            // Direct operand column; the spare code sits here
            case (op[7:4])
              4'h7, 4'h8: decode = `ENT_3_3;
              4'hb, 4'hd: decode = `ENT_B_3_4;
              4'ha: decode = `ENT_1_1;
              default: decode = `ENT_2_2;
            endcase
          end
          4'h4:
          begin
            // Immediate and accumulator-only column
            case (op[7:4])
              4'h0, 4'h1, 4'hc, 4'hd: decode = `ENT_1_1;
              4'he, 4'hf: decode = `ENT_1_1;
              4'h8: decode = `ENT_1_8;
              4'ha: decode = `ENT_1_4;
              4'hb: decode = `ENT_B_3_4;
              default: decode = `ENT_2_2;
            endcase
          end
          4'h0:
          begin
            // Bit branches, short jumps and the pointer load
            case (op[7:4])
              4'h0: decode = `ENT_1_1;
              4'h1, 4'h2, 4'h3: decode = `ENT_B_3_4;
              4'h4, 4'h5, 4'h6, 4'h7: decode = `ENT_B_2_3;
              4'h8: decode = `ENT_2_3;
              4'h9: decode = `ENT_3_3;
              4'he, 4'hf: decode = `ENT_1_3;
              default: decode = `ENT_2_2;
            endcase
          end
          4'h2:
          begin
            // Long transfers, returns and direct-bit operations
            case (op[7:4])
              4'h0, 4'h1: decode = `ENT_3_4;
              4'h2, 4'h3: decode = `ENT_1_5;
              4'he, 4'hf: decode = `ENT_1_3;
              default: decode = `ENT_2_2;
            endcase
          end
          default:
          begin
            // Column 3
            case (op[7:4])
              4'h4, 4'h5, 4'h6: decode = `ENT_3_3;
              4'h7: decode = `ENT_1_3;
              4'h8, 4'h9: decode = `ENT_1_3;
              4'he, 4'hf: decode = `ENT_1_3;
              default: decode = `ENT_1_1;
            endcase
          end
        endcase
      end
    end
  endfunction

  // Flash-facing move, either direction
  function is_ext_move;
    input [7:0] op;
    input wr;
    begin
      if (wr)
        is_ext_move = (op == `OP_XWR_DP) || (op == `OP_XWR_R0) || (op == `OP_XWR_R1);
      else
        is_ext_move = (op == `OP_XRD_DP) || (op == `OP_XRD_R0) || (op == `OP_XRD_R1);
    end
  endfunction

  // One clock less; shared by the not-taken shortening and the down-count
  function [3:0] dec_clk;
    input [3:0] n;
    begin
      dec_clk = n - `CLK_ONE;
    end
  endfunction

  // Table entry fields and class hits of the offered opcode
  wire issue;
  wire [`ENT_W-1:0] ent;
  wire ent_cond;
  wire [1:0] ent_len;
  wire [3:0] ent_clk;
  wire short_path;
  wire [3:0] eff_clk;
  wire last_clk;
  wire op_rd;
  wire op_wr;
  wire op_code;
  wire op_flash;

  // Decode of the opcode offered in this cycle
  assign issue = ready_q & issue_valid;
  assign ent = decode(issue_opcode);
  assign ent_cond = ent[`ENT_COND];
  assign ent_len = ent[`ENT_LEN_HI:`ENT_LEN_LO];
  assign ent_clk = ent[`ENT_CLK_HI:`ENT_CLK_LO];
  assign short_path = ent_cond & branch_fail;
  assign eff_clk = short_path ? dec_clk(ent_clk) : ent_clk;
  assign last_clk = (eff_clk == `CLK_ONE);
  assign op_rd = is_ext_move(issue_opcode, 1'b0);
  assign op_wr = is_ext_move(issue_opcode, 1'b1);
  assign op_code = (issue_opcode == `OP_CODE_PC) || (issue_opcode == `OP_CODE_DP);
  assign op_flash = op_rd | op_wr | op_code;

  // Down-counter and next-state copies of every flip-flop
  reg [3:0] remain_q;
  reg [3:0] remain_d;
  reg [3:0] phase_d;
  reg ready_d;
  reg done_d;
  reg [1:0] len_d;
  reg [3:0] clocks_d;
  reg byte_fetch_d;
  reg cond_d;
  reg taken_d;
  reg rd_d;
  reg wr_d;
  reg wide_d;
  reg code_d;
  reg strobe_d;
  reg acc_load_d;
  reg mul_d;
  reg div_d;
  reg nop_d;
  reg [3:0] phase_nx;
  reg flash_op_q;
  reg flash_op_d;
  wire final_clk;

  // Next clock is the last one of a multi-clock instruction in progress
  assign final_clk = (remain_q == `CLK_ONE);

  // Next state; counts whole clocks only, so no machine-cycle divider exists
  always @*
  begin
    phase_nx = phase_q + `CLK_ONE;
    remain_d = remain_q;
    phase_d = phase_q;
    ready_d = ready_q;
    done_d = `FLAG_RST;
    len_d = len_q;
    clocks_d = clocks_q;
    byte_fetch_d = `FLAG_RST;
    cond_d = cond_q;
    taken_d = taken_q;
    rd_d = ext_data_move_rd_q;
    wr_d = ext_data_move_wr_q;
    wide_d = ext_data_move_wide_q;
    code_d = code_byte_fetch_q;
    strobe_d = `FLAG_RST;
    acc_load_d = `FLAG_RST;
    mul_d = multiply_acc_second_q;
    div_d = divide_acc_second_q;
    nop_d = nop_q;
    flash_op_d = flash_op_q;
    if (issue)
    begin
      // First clock of a new instruction
      remain_d = dec_clk(eff_clk);
      phase_d = `CLK_ZERO;
      ready_d = last_clk;
      done_d = last_clk;
      len_d = ent_len;
      clocks_d = eff_clk;
      byte_fetch_d = (ent_len != `LEN_ZERO);
      cond_d = ent_cond;
      taken_d = ent_cond & ~branch_fail;
      rd_d = op_rd;
      wr_d = op_wr;
      wide_d = (issue_opcode == `OP_XRD_DP) || (issue_opcode == `OP_XWR_DP);
      code_d = op_code;
      flash_op_d = op_flash;
      strobe_d = `FLAG_RST;
      acc_load_d = last_clk & (op_rd | op_code);
      mul_d = (issue_opcode == `OP_MUL);
      div_d = (issue_opcode == `OP_DIV);
      nop_d = (issue_opcode == `OP_NOP) || (issue_opcode == `OP_UNUSED);
    end
    else if (remain_q != `CLK_ZERO)
    begin
      // Later clocks of a multi-clock instruction
      remain_d = dec_clk(remain_q);
      phase_d = phase_nx;
      ready_d = final_clk;
      done_d = final_clk;
      byte_fetch_d = ({2'h0, len_q} > phase_nx);
      // Flash is touched once, in the second clock, so the array sees one access per move
      strobe_d = (phase_nx == `PHASE_ONE) & flash_op_q;
      acc_load_d = final_clk & (rd_d | code_d);
    end
    else
    begin
      // Idle: class levels fall after completion; len_q and clocks_q keep the last instruction's values
      phase_d = `CLK_ZERO;
      rd_d = `FLAG_RST;
      wr_d = `FLAG_RST;
      wide_d = `FLAG_RST;
      code_d = `FLAG_RST;
      mul_d = `FLAG_RST;
      div_d = `FLAG_RST;
      nop_d = `FLAG_RST;
      cond_d = `FLAG_RST;
      taken_d = `FLAG_RST;
      flash_op_d = `FLAG_RST;
    end
  end

  // State and outputs; every output is a flip-flop
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      remain_q <= `CLK_ZERO;
      phase_q <= `CLK_ZERO;
      ready_q <= `READY_RST;
      done_q <= `FLAG_RST;
      len_q <= `LEN_ZERO;
      clocks_q <= `CLK_ZERO;
      byte_fetch_q <= `FLAG_RST;
      cond_q <= `FLAG_RST;
      taken_q <= `FLAG_RST;
      ext_data_move_rd_q <= `FLAG_RST;
      ext_data_move_wr_q <= `FLAG_RST;
      ext_data_move_wide_q <= `FLAG_RST;
      code_byte_fetch_q <= `FLAG_RST;
      flash_strobe_q <= `FLAG_RST;
      acc_load_q <= `FLAG_RST;
      multiply_acc_second_q <= `FLAG_RST;
      divide_acc_second_q <= `FLAG_RST;
      nop_q <= `FLAG_RST;
      flash_op_q <= `FLAG_RST;
    end
    else
    begin
      remain_q <= remain_d;
      phase_q <= phase_d;
      ready_q <= ready_d;
      done_q <= done_d;
      len_q <= len_d;
      clocks_q <= clocks_d;
      byte_fetch_q <= byte_fetch_d;
      cond_q <= cond_d;
      taken_q <= taken_d;
      ext_data_move_rd_q <= rd_d;
      ext_data_move_wr_q <= wr_d;
      ext_data_move_wide_q <= wide_d;
      code_byte_fetch_q <= code_d;
      flash_strobe_q <= strobe_d;
      acc_load_q <= acc_load_d;
      multiply_acc_second_q <= mul_d;
      divide_acc_second_q <= div_d;
      nop_q <= nop_d;
      flash_op_q <= flash_op_d;
    end
  end

  // Limitation: the core is only rated up to MAX_FREQ_MHZ; the counts hold at any rate

endmodule
`default_nettype wire

// [hdl/cpu_timing_defines.vh]
// Opcode constants and timing table entries for the instruction cycle sequencer
`ifndef CPU_TIMING_DEFINES_VH
`define CPU_TIMING_DEFINES_VH

// Table entry layout: {conditional, bytes[1:0], taken clocks[3:0]}
`define ENT_W 7
`define ENT_COND 6
`define ENT_LEN_HI 5
`define ENT_LEN_LO 4
`define ENT_CLK_HI 3
`define ENT_CLK_LO 0

// Plain entries, bytes then clocks
`define ENT_1_1 7'h11
`define ENT_1_2 7'h12
`define ENT_1_3 7'h13
`define ENT_1_4 7'h14
`define ENT_1_5 7'h15
`define ENT_1_8 7'h18
`define ENT_2_2 7'h22
`define ENT_2_3 7'h23
`define ENT_3_3 7'h33
`define ENT_3_4 7'h34

// Conditional branches, taken clock count stored
`define ENT_B_2_3 7'h63
`define ENT_B_3_4 7'h74
`define ENT_B_3_5 7'h75

// Opcodes with side effects beyond timing
`define OP_NOP 8'h00
`define OP_UNUSED 8'ha5
`define OP_MUL 8'ha4
`define OP_DIV 8'h84
`define OP_CODE_PC 8'h83
`define OP_CODE_DP 8'h93
`define OP_XRD_DP 8'he0
`define OP_XRD_R0 8'he2
`define OP_XRD_R1 8'he3
`define OP_XWR_DP 8'hf0
`define OP_XWR_R0 8'hf2
`define OP_XWR_R1 8'hf3

// Counts and reset values
`define CLK_ZERO 4'h0
`define CLK_ONE 4'h1
`define LEN_ZERO 2'h0
`define PHASE_ONE 4'h1
`define READY_RST 1'b1
`define FLAG_RST 1'b0
`define MAX_FREQ_MHZ 25

`endif
